// *** testbench.sv ***
// Self-checking bench for the trace scan acquisition block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import tsa_pkg::*;
    logic clk_i = 0, rstn_i = 0, beg = 0, pau = 0, rwr = 0, lwr = 0, mwr = 0;
    logic loop = 0, tst = 0, fire = 0, pin, loop_o, step, rst_p;
    logic [3:0] rate = 4'h4, sel = 4'hF, sel_o, rate_o;
    logic [15:0] len = 16'h0001, rbin = 16'h0000, n = 16'h0000, rd, pts, dep, fill, idx;
    logic [1:0] rtr = 2'h0;
    logic [2:0] st;
    int fails = 0, total_checks = 0, steps = 0, rsts = 0, s0, k;
    // Short sample periods keep the run brief: rate 13 is two cycles
    tsa_acq #(.SLOW_CYC(16384), .TRIG_HOLD_CYC(8)) tsa_acq_inst (
        .clk_i(clk_i), .rstn_i(rstn_i), .begin_or_resume_command_i(beg),
        .pause_reset_i(pau), .trig_pin_i(pin), .rate_wr_i(rwr), .rate_i(rate),
        .len_wr_i(lwr), .len_i(len), .mode_wr_i(mwr), .store_sel_i(sel),
        .loop_i(loop), .trig_start_i(tst), .trace0_i(n), .trace1_i(n + 16'h0100),
        .trace2_i(n + 16'h0200), .trace3_i(n + 16'h0300), .rd_trace_i(rtr),
        .rd_bin_i(rbin), .rd_data_o(rd), .state_o(st), .store_sel_o(sel_o),
        .rate_o(rate_o), .loop_o(loop_o), .points_o(pts), .depth_o(dep),
        .fill_o(fill), .sweep_step_o(step), .sweep_restart_o(rst_p), .sweep_idx_o(idx));
    tsa_trig_src tsa_trig_src_inst (.clk_i(clk_i), .fire_i(fire), .pin_o(pin));
    initial
    begin
        forever #50 clk_i = ~clk_i;
    end
    // Detector values follow the sweep point, so bins show order
    always @(posedge clk_i)
    begin
        if (step) n <= n + 16'h0001;
        if (step) steps <= steps + 1;
        if (rst_p) n <= 16'h0000;
        if (rst_p) rsts <= rsts + 1;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Kind 0 begin, 1 pause, 2 rate, 3 length, 4 mode {trig,loop,sel}
    task automatic cfg(input int kd, input logic [15:0] v);
        @(posedge clk_i);
        if (kd == 2) rate <= v[3:0];
        if (kd == 3) len <= v;
        if (kd == 4) {tst, loop, sel} <= v[5:0];
        @(posedge clk_i);
        beg <= (kd == 0);
        pau <= (kd == 1);
        rwr <= (kd == 2);
        lwr <= (kd == 3);
        mwr <= (kd == 4);
        @(posedge clk_i);
        {beg, pau, rwr, lwr, mwr} <= 5'h00;
        #1;
    endtask : cfg
    // Bounded wait on state (kd 0) or fill (kd 1)
    task automatic waitv(input int kd, input logic [15:0] v);
        for (int i = 0; i < 3000; i++)
        begin
            if ((kd == 0 && st === v[2:0]) || (kd == 1 && fill === v)) break;
            @(posedge clk_i);
            #1;
        end
    endtask : waitv
    // Readout is registered: give it two edges before looking
    task automatic rdchk(input logic [1:0] t, input logic [15:0] b, input logic [15:0] e);
        @(posedge clk_i);
        rtr <= t;
        rbin <= b;
        repeat (2) @(posedge clk_i);
        #1;
        chk(rd, e);
    endtask : rdchk
    task automatic trig();
        @(posedge clk_i);
        fire <= 1'b1;
        @(posedge clk_i);
        fire <= 1'b0;
    endtask : trig
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : summarize
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        #5_000_000;
        fails++;
        summarize();
    end
    initial
    begin
        repeat (3) @(posedge clk_i);
        rstn_i <= 1'b1;
        #1;
        chk(st, 16'h0000);
        chk(sel_o, STORE_RST);
        chk(rate_o, 16'h0004);
        chk(loop_o, 16'h0001);
        chk(pts, 16'h3E80);
        chk(fill, 16'h0000);
        cfg(4, 16'h0001); chk(dep, DEPTH_ONE);
        cfg(4, 16'h0003); chk(dep, DEPTH_TWO);
        cfg(4, 16'h000F); chk(dep, DEPTH_FOUR);
        cfg(3, 16'h0000); chk(pts, 16'h0001);
        cfg(3, 16'hFFFF); chk(pts, 16'h3E80);
        cfg(3, 16'h0064); cfg(2, 16'h0005); chk(pts, 16'h00C8);
        cfg(3, 16'hFFFF); cfg(2, 16'h0006); chk(pts, 16'h3E80);
        // One-shot scan of three points at 512 Hz
        cfg(2, 16'h000D); cfg(3, 16'h0003); s0 = steps;
        cfg(0, 16'h0000); waitv(0, 16'h0004);
        chk(st, 16'h0004);
        chk(fill, 16'h0003);
        chk(16'(steps - s0), 16'h0002);
        repeat (20) @(posedge clk_i);
        #1;
        chk(idx, 16'h0002);
        for (k = 0; k < 4; k++) rdchk(k[1:0], 16'h0001, 16'h0001 + 16'(k * 256));
        for (k = 0; k < 3; k++) rdchk(2'h0, 16'(k), 16'(k));
        // Looping scan keeps going past its length
        cfg(4, 16'h001F); s0 = rsts;
        cfg(0, 16'h0000); waitv(1, 16'h0007);
        chk(fill, 16'h0007);
        chk(16'(rsts - s0), 16'h0003);
        chk(idx, 16'h0001);
        rdchk(2'h0, 16'h0005, 16'h0002);
        // Slow rate so commands never land in a write burst
        cfg(2, 16'h0000); repeat (6) @(posedge clk_i);
        cfg(1, 16'h0000); chk(st, 16'h0003);
        cfg(0, 16'h0000); chk(st, 16'h0001);
        cfg(1, 16'h0000); cfg(1, 16'h0000); chk(st, 16'h0000);
        chk(fill, 16'h0000);
        // Triggered sampling, trigger also starts the scan
        cfg(2, 16'h000F); chk(rate_o, RATE_TRIG);
        cfg(4, 16'h002F); cfg(3, 16'h0005);
        trig(); repeat (10) @(posedge clk_i); #1;
        chk(st, 16'h0001);
        chk(fill, 16'h0000);
        trig(); repeat (15) @(posedge clk_i); #1;
        chk(fill, 16'h0001);
        trig(); repeat (4) @(posedge clk_i); trig(); repeat (30) @(posedge clk_i); #1;
        chk(fill, 16'h0002);
        // Mid-run reset must bring back the default scan
        @(posedge clk_i);
        rstn_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        rstn_i <= 1'b1;
        #1;
        chk(st, 16'h0000);
        chk(rate_o, 16'h0004);
        chk(loop_o, 16'h0001);
        chk(pts, 16'h3E80);
        chk(fill, 16'h0000);
        chk(idx, 16'h0000);
        // Trigger start is off after reset, so an edge must not start
        trig();
        repeat (10) @(posedge clk_i);
        #1;
        chk(st, 16'h0000);
        summarize();
    end
endmodule : testbench
`default_nettype wire

// *** tsa_acq.sv ***
// Trace scan acquisition: sample timing, shared buffer, scan control
//
// Notes on behaviour
// R1 - Depth 64000, 32000 or 16000 per trace
// R2 - Per-trace store select, all set at reset
// R3 - Bins numbered oldest zero to N-1
// R4 - Internal rates 512 Hz down to 62.5 mHz
// R5 - Stored traces sampled on one instant
// R6 - Rate code past 512 Hz selects trigger
// R7 - Triggered sample recorded within 2 ms
// R8 - Triggers faster than 512 Hz ignored
// R9 - Rate change keeps duration unless length maxed
// R10 - Scan length from 1 to depth
// R11 - One scan length for all traces
// R12 - Sweep steps once per stored point
// R13 - Store trace data, then step sweep
// R14 - One shot stops, sweep held at end
// R15 - Loop restarts scan immediately, indefinitely
// R16 - Loop uses full depth and wraps
// R17 - After wrap, oldest reads at bin zero
// R18 - Reset: four traces, 16000, 1 Hz, loop
// R19 - Begin/resume and pause/reset commands
// R20 - Trigger may act as begin command
// R21 - Starting trigger does not record sample
// R22 - Pause/reset when paused or done clears
// R23 - Trigger synchronised and edge registered
`timescale 1ns/1ps
`default_nettype none
module tsa_acq
    import tsa_pkg::*;
#(
    parameter int unsigned DATA_W = 16,
    parameter int unsigned SLOW_CYC = SLOW_PERIOD_CYC,
    parameter int unsigned TRIG_HOLD_CYC = TRIG_MIN_CYC
)(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic begin_or_resume_command_i,
    input wire logic pause_reset_i,
    input wire logic trig_pin_i,
    input wire logic rate_wr_i,
    input wire logic [3:0] rate_i,
    input wire logic len_wr_i,
    input wire logic [15:0] len_i,
    input wire logic mode_wr_i,
    input wire logic [3:0] store_sel_i,
    input wire logic loop_i,
    input wire logic trig_start_i,
    input wire logic [DATA_W-1:0] trace0_i,
    input wire logic [DATA_W-1:0] trace1_i,
    input wire logic [DATA_W-1:0] trace2_i,
    input wire logic [DATA_W-1:0] trace3_i,
    input wire logic [1:0] rd_trace_i,
    input wire logic [15:0] rd_bin_i,
    output logic [DATA_W-1:0] rd_data_o,
    output logic [2:0] state_o,
    output logic [3:0] store_sel_o,
    output logic [3:0] rate_o,
    output logic loop_o,
    output logic [15:0] points_o,
    output logic [15:0] depth_o,
    output logic [15:0] fill_o,
    output logic sweep_step_o,
    output logic sweep_restart_o,
    output logic [15:0] sweep_idx_o
);
    ////////////////////////////////////////////////////////////////////////////
    // Helper functions

    // R1 depth by stored count
    function automatic logic [15:0] depth_of(input logic [3:0] sel);
        logic [2:0] n;
        n = 3'(sel[0]) + 3'(sel[1]) + 3'(sel[2]) + 3'(sel[3]);
        if (n == 3'h1)
            return DEPTH_ONE;
        else if (n == 3'h2)
            return DEPTH_TWO;
        else
            return DEPTH_FOUR;
    endfunction : depth_of

    // Position of a trace among the stored ones
    function automatic logic [1:0] slot_of(input logic [3:0] sel, input logic [1:0] trc);
        logic [1:0] s;
        s = 2'h0;
        for (int i = 0; i < 3; i++)
        begin
            if (i < int'(trc) && sel[i])
                s = s + 2'h1;
        end
        return s;
    endfunction : slot_of

    // R10 clamp length into 1..depth
    function automatic logic [15:0] clamp_len(input logic [31:0] v, input logic [15:0] d);
        if (v == 32'h0)
            return 16'h1;
        else if (v > 32'(d))
            return d;
        else
            return v[15:0];
    endfunction : clamp_len

    // R4 sample interval in cycles, minus one
    function automatic logic [27:0] period_of(input logic [3:0] r);
        logic [31:0] p;
        p = 32'(SLOW_CYC) >> r;
        return 28'(p - 32'h1);
    endfunction : period_of

    ////////////////////////////////////////////////////////////////////////////
    // State
    tsa_state_t state_r, state_nxt;
    logic [3:0] store_r, store_nxt;
    logic [3:0] rate_r, rate_nxt;
    logic loop_r, loop_nxt;
    logic tstart_r, tstart_nxt;
    logic [15:0] points_r, points_nxt;
    logic [15:0] bin_r, bin_nxt;
    logic [15:0] pt_r, pt_nxt;
    logic [15:0] fill_r, fill_nxt;
    logic wrapped_r, wrapped_nxt;
    logic [27:0] tmr_r, tmr_nxt;
    logic [1:0] trc_r, trc_nxt;
    logic [1:0] slot_r, slot_nxt;
    logic step_r, step_nxt;
    logic restart_r, restart_nxt;
    logic [15:0] sidx_r, sidx_nxt;
    logic [DATA_W-1:0] smp_r [TRACES];
    logic [DATA_W-1:0] smp_nxt [TRACES];
    logic [DATA_W-1:0] rd_r;
    logic [DATA_W-1:0] mem [0:DEPTH_ONE-1];
    logic mem_we;
    logic [15:0] mem_addr, rd_addr, rd_phys, depth;
    logic [16:0] rd_sum;
    logic trig_edge, start_cmd, tick;

    // Trigger front end
    tsa_trig #(
        .HOLD_CYC(TRIG_HOLD_CYC)
    ) u_trig (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .pin_i(trig_pin_i),
        .edge_o(trig_edge)
    );

    assign depth = depth_of(store_r);
    // R20 trigger acts as begin
    assign start_cmd = begin_or_resume_command_i || (tstart_r && trig_edge);
    // R6 trigger mode replaces timer
    // R7 edge ticks within cycles
    assign tick = (rate_r == RATE_TRIG) ? trig_edge : (tmr_r == 28'h0);

    ////////////////////////////////////////////////////////////////////////////
    // Configuration and scan control next values
    always_comb
    begin
        logic [31:0] scaled;
        scaled = 32'h0;
        state_nxt = state_r;
        store_nxt = store_r;
        rate_nxt = rate_r;
        loop_nxt = loop_r;
        tstart_nxt = tstart_r;
        points_nxt = points_r;
        bin_nxt = bin_r;
        pt_nxt = pt_r;
        fill_nxt = fill_r;
        wrapped_nxt = wrapped_r;
        tmr_nxt = tmr_r;
        trc_nxt = trc_r;
        slot_nxt = slot_r;
        step_nxt = 1'b0;
        restart_nxt = 1'b0;
        sidx_nxt = sidx_r;
        smp_nxt = smp_r;
        // Free-running interval timer, reloaded on each expiry
        if (rate_r != RATE_TRIG)
            tmr_nxt = (tmr_r == 28'h0) ? period_of(rate_r) : tmr_r - 28'h1;
        // R9 rescale length on rate change
        if (rate_wr_i)
        begin
            // R6 codes past 512 Hz mean trigger
            rate_nxt = (rate_i > RATE_MAX_INT) ? RATE_TRIG : rate_i;
            tmr_nxt = period_of(rate_nxt);
            if (points_r != depth && rate_nxt != RATE_TRIG && rate_r != RATE_TRIG)
            begin
                if (rate_nxt > rate_r)
                    scaled = 32'(points_r) << (rate_nxt - rate_r);
                else
                    scaled = 32'(points_r) >> (rate_r - rate_nxt);
                points_nxt = clamp_len(scaled, depth);
            end
        end
        // R10 explicit length, clamped
        // R11 one length for all traces
        if (len_wr_i)
            points_nxt = clamp_len(32'(len_i), depth);
        // R2 store selection per trace
        if (mode_wr_i)
        begin
            store_nxt = store_sel_i;
            loop_nxt = loop_i;
            tstart_nxt = trig_start_i;
            points_nxt = clamp_len(32'(len_wr_i ? len_i : points_r), depth_of(store_sel_i));
        end
        // R19 command handling per state
        case (state_r)
            TSA_STOP, TSA_DONE:
            begin
                if (start_cmd)
                begin
                    // R21 starting edge only starts
                    state_nxt = TSA_RUN;
                    bin_nxt = 16'h0;
                    pt_nxt = 16'h0;
                    fill_nxt = 16'h0;
                    wrapped_nxt = 1'b0;
                    sidx_nxt = 16'h0;
                    restart_nxt = 1'b1;
                    tmr_nxt = period_of(rate_r);
                end
                // R22 reset finished scan
                else if (pause_reset_i)
                begin
                    state_nxt = TSA_STOP;
                    bin_nxt = 16'h0;
                    pt_nxt = 16'h0;
                    fill_nxt = 16'h0;
                    wrapped_nxt = 1'b0;
                end
            end
            TSA_RUN:
            begin
                if (pause_reset_i)
                    state_nxt = TSA_PAUSE;
                // R5 latch all traces at once
                else if (tick)
                begin
                    state_nxt = TSA_WRITE;
                    smp_nxt[0] = trace0_i;
                    smp_nxt[1] = trace1_i;
                    smp_nxt[2] = trace2_i;
                    smp_nxt[3] = trace3_i;
                    trc_nxt = 2'h0;
                    slot_nxt = 2'h0;
                end
            end
            TSA_WRITE:
            begin
                trc_nxt = trc_r + 2'h1;
                if (store_r[trc_r])
                    slot_nxt = slot_r + 2'h1;
                if (trc_r == 2'h3)
                begin
                    state_nxt = TSA_RUN;
                    fill_nxt = (fill_r == depth) ? fill_r : fill_r + 16'h1;
                    // R16 loop wraps at full depth
                    if (bin_r + 16'h1 >= depth)
                    begin
                        bin_nxt = 16'h0;
                        wrapped_nxt = 1'b1;
                    end
                    else
                        bin_nxt = bin_r + 16'h1;
                    if (pt_r + 16'h1 >= points_r)
                    begin
                        pt_nxt = 16'h0;
                        // R15 loop restarts at once
                        if (loop_r)
                        begin
                            restart_nxt = 1'b1;
                            sidx_nxt = 16'h0;
                        end
                        // R14 one shot holds sweep
                        else
                            state_nxt = TSA_DONE;
                    end
                    else
                    begin
                        // R12 one step per point
                        // R13 step after data stored
                        pt_nxt = pt_r + 16'h1;
                        step_nxt = 1'b1;
                        sidx_nxt = sidx_r + 16'h1;
                    end
                end
            end
            TSA_PAUSE:
            begin
                if (start_cmd)
                begin
                    state_nxt = TSA_RUN;
                    tmr_nxt = period_of(rate_r);
                end
                // R22 reset paused scan
                else if (pause_reset_i)
                begin
                    state_nxt = TSA_STOP;
                    bin_nxt = 16'h0;
                    pt_nxt = 16'h0;
                    fill_nxt = 16'h0;
                    wrapped_nxt = 1'b0;
                end
            end
            default:
                state_nxt = TSA_STOP;
        endcase
    end

    // R18 default scan after reset
    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            state_r <= TSA_STOP;
            store_r <= STORE_RST;
            rate_r <= RATE_RST;
            loop_r <= LOOP_RST;
            tstart_r <= TSTART_RST;
            points_r <= LEN_RST;
            bin_r <= 16'h0;
            pt_r <= 16'h0;
            fill_r <= 16'h0;
            wrapped_r <= 1'b0;
            tmr_r <= 28'h0;
            trc_r <= 2'h0;
            slot_r <= 2'h0;
            step_r <= 1'b0;
            restart_r <= 1'b0;
            sidx_r <= 16'h0;
            for (int i = 0; i < TRACES; i++)
                smp_r[i] <= '0;
        end
        else
        begin
            state_r <= state_nxt;
            store_r <= store_nxt;
            rate_r <= rate_nxt;
            loop_r <= loop_nxt;
            tstart_r <= tstart_nxt;
            points_r <= points_nxt;
            bin_r <= bin_nxt;
            pt_r <= pt_nxt;
            fill_r <= fill_nxt;
            wrapped_r <= wrapped_nxt;
            tmr_r <= tmr_nxt;
            trc_r <= trc_nxt;
            slot_r <= slot_nxt;
            step_r <= step_nxt;
            restart_r <= restart_nxt;
            sidx_r <= sidx_nxt;
            smp_r <= smp_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shared buffer: one trace per cycle keeps a single write port
    assign mem_we = (state_r == TSA_WRITE) && store_r[trc_r];
    assign mem_addr = 16'(slot_r * depth) + bin_r;
    // R3 bin zero is the oldest
    // R17 rotate by write pointer
    assign rd_sum = 17'(bin_r) + 17'(rd_bin_i);
    assign rd_phys = !wrapped_r ? rd_bin_i :
        (rd_sum >= 17'(depth)) ? 16'(rd_sum - 17'(depth)) : rd_sum[15:0];
    assign rd_addr = 16'(slot_of(store_r, rd_trace_i) * depth) + rd_phys;

    // Buffer contents are not reset; the pointers define what is valid
    always_ff @(posedge clk_i)
    begin
        if (mem_we)
            mem[mem_addr] <= smp_r[trc_r];
        rd_r <= mem[rd_addr];
    end

    assign rd_data_o = rd_r;
    assign state_o = state_r;
    assign store_sel_o = store_r;
    assign rate_o = rate_r;
    assign loop_o = loop_r;
    assign points_o = points_r;
    assign depth_o = depth;
    assign fill_o = fill_r;
    assign sweep_step_o = step_r;
    assign sweep_restart_o = restart_r;
    assign sweep_idx_o = sidx_r;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    sequence write_burst_s;
        (state_r == TSA_WRITE) [*4] ##1 (state_r != TSA_WRITE);
    endsequence

    depth_map_a: // R1
        assert property ((store_r == 4'h1 |-> depth == DEPTH_ONE)
            and (store_r == 4'h3 |-> depth == DEPTH_TWO)
            and (store_r == 4'hF |-> depth == DEPTH_FOUR))
        else $error("depth does not match stored count");
    reset_default_a: // R18
        assert property ($rose(rstn_i) |-> store_r == STORE_RST && rate_r == RATE_RST
            && points_r == LEN_RST && loop_r)
        else $error("default scan not restored by reset");
    trig_mode_a: // R6
        assert property (rate_wr_i && rate_i > RATE_MAX_INT |=> rate_r == RATE_TRIG)
        else $error("rate past maximum did not select trigger");
    trig_latency_a: // R7
        assert property (state_r == TSA_RUN && rate_r == RATE_TRIG && trig_edge
            && !pause_reset_i |=> write_burst_s)
        else $error("trigger did not record a sample");
    len_range_a: // R10
        assert property (points_r != 16'h0 && points_r <= depth)
        else $error("scan length out of range");
    store_first_a: // R13
        assert property (step_r |-> $past(state_r == TSA_WRITE) && $past(trc_r) == 2'h3
            && state_r == TSA_RUN)
        else $error("sweep stepped before data stored");
    shot_hold_a: // R14
        assert property (state_r == TSA_DONE && $past(state_r == TSA_DONE)
            |-> $stable(sidx_r) && !step_r)
        else $error("sweep moved after one shot end");
    loop_restart_a: // R15
        assert property (restart_r && $past(state_r == TSA_WRITE) |-> state_r == TSA_RUN
            && pt_r == 16'h0 && sidx_r == 16'h0)
        else $error("loop did not restart scan");
    wrap_bin_a: // R16
        assert property (state_r == TSA_WRITE && trc_r == 2'h3 && bin_r + 16'h1 == depth
            |=> bin_r == 16'h0 && wrapped_r)
        else $error("buffer did not wrap at depth");
    clear_stop_a: // R22
        assert property (state_r == TSA_PAUSE && pause_reset_i && !start_cmd
            |=> state_r == TSA_STOP && fill_r == 16'h0 && bin_r == 16'h0)
        else $error("pause reset did not clear buffer");
endmodule : tsa_acq
`default_nettype wire

// *** tsa_pkg.sv ***
// Shared constants and types for the trace scan acquisition block
`default_nettype none
package tsa_pkg;
    // Clock and buffer geometry
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned TRACES = 4;
    localparam int unsigned BIN_W = 16;
    localparam logic [15:0] DEPTH_ONE = 16'hFA00;  // 64000 points, one trace
    localparam logic [15:0] DEPTH_TWO = 16'h7D00;  // 32000 points, two traces
    localparam logic [15:0] DEPTH_FOUR = 16'h3E80; // 16000 points, three or four
    ////////////////////////////////////////////////////////////////////////////
    // Rate codes: code k samples at 62.5 mHz * 2**k
    localparam logic [3:0] RATE_MAX_INT = 4'hD; // 512 Hz
    localparam logic [3:0] RATE_TRIG = 4'hE;    // External trigger sampling
    localparam int unsigned SLOW_PERIOD_S = 16; // Slowest sample interval
    localparam int unsigned SLOW_PERIOD_CYC = SLOW_PERIOD_S * CLK_HZ;
    // Shortest accepted trigger spacing, 1/512 s, rounded down
    localparam int unsigned TRIG_MIN_NS = 1_953_125;
    localparam int unsigned TRIG_MIN_CYC = TRIG_MIN_NS / (1_000_000_000 / CLK_HZ);
    ////////////////////////////////////////////////////////////////////////////
    // Values after reset: four traces, 1 Hz, 16000 points, loop
    localparam logic [3:0] STORE_RST = 4'hF;
    localparam logic [3:0] RATE_RST = 4'h4;
    localparam logic [15:0] LEN_RST = 16'h3E80;
    localparam logic LOOP_RST = 1'b1;
    localparam logic TSTART_RST = 1'b0;
    // Scan states
    typedef enum logic [2:0] {TSA_STOP, TSA_RUN, TSA_WRITE, TSA_PAUSE, TSA_DONE} tsa_state_t;
endpackage : tsa_pkg
`default_nettype wire

// *** tsa_trig.sv ***
// Trigger pin synchroniser, rising edge detector and rate limiter
`timescale 1ns/1ps
`default_nettype none
module tsa_trig
    import tsa_pkg::*;
#(
    parameter int unsigned HOLD_CYC = TRIG_MIN_CYC,
    parameter int unsigned CNT_W = 15
)(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic pin_i,
    output logic edge_o
);
    logic sync1_r, sync2_r, prev_r, edge_r;
    logic edge_nxt;
    logic [CNT_W-1:0] hold_r, hold_nxt;
    ////////////////////////////////////////////////////////////////////////////
    // Next values: accept an edge only after the hold time has run out
    always_comb
    begin
        edge_nxt = 1'b0;
        hold_nxt = hold_r;
        if (hold_r != '0)
        begin
            hold_nxt = hold_r - 1'b1;
        end
        // R23 registered edge detect
        // R8 drop fast triggers
        if (sync2_r && !prev_r && hold_r == '0)
        begin
            edge_nxt = 1'b1;
            hold_nxt = CNT_W'(HOLD_CYC - 1);
        end
    end
    // Pin passes two flops before the detector looks at it
    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            prev_r <= 1'b0;
            edge_r <= 1'b0;
            hold_r <= '0;
        end
        else
        begin
            sync1_r <= pin_i;
            sync2_r <= sync1_r;
            prev_r <= sync2_r;
            edge_r <= edge_nxt;
            hold_r <= hold_nxt;
        end
    end
    assign edge_o = edge_r;
endmodule : tsa_trig
`default_nettype wire

// *** tsa_trig_src.sv ***
// Trigger source model for the rear trigger pin
`timescale 1ns/1ps
`default_nettype none
module tsa_trig_src (
    input wire logic clk_i,
    input wire logic fire_i,
    output logic pin_o
);
    logic [1:0] cnt_r = 2'h0;
    // spacing set by requests
    // Two-cycle pulse per request; idle low so edges stay clean
    always_ff @(posedge clk_i)
    begin
        if (fire_i)
            cnt_r <= 2'h2;
        else if (cnt_r != 2'h0)
            cnt_r <= cnt_r - 2'h1;
    end
    assign pin_o = (cnt_r != 2'h0);
endmodule : tsa_trig_src
`default_nettype wire
